/* hw/ppoi_top.sv */
// peripheral parallel port output line control and interrupt register bank
// Contract
// - manual control drives all five handshake outputs from output value bits
// - compatibility and epp: state machine drives busy, strobe; register drives others
// - ecp mode without manual control: output value register has no effect, ecp logic drives lines
// - busy and strobe bits reach pins only under manual control
// - ack request bit is paper error in compatibility, user 1 in epp
// - flag bit is select in compatibility, user 2 in epp
// - data available low bit is fault low in compatibility, user 3 in epp
// - each enable bit gates the status bit at the same position
// - any write to the status register clears pending bits and the request
// - negotiation change sets its flag and new status becomes readable
// - signal change only in manual control; leaving manual keeps it pending
// - epp address write stores the address and sets its flag
// - host direction reversal sets the direction change flag
// - host identity request sets the identity request flag
// - compatibility mode without manual control: leading edge of init low pulse raises its flag
// - a rising edge select bit makes low-to-high on that input qualify
// - a configuration bit enters manual control of all lines
`timescale 1ns/1ps
module ppoi_top import ppoi_pkg::*; (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [ADR_W-1:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [DAT_W-1:0] DAT_I,
   output logic [DAT_W-1:0] DAT_O,
   output logic ACK_O,
   input wire logic [3:0] HOST_LINES,
   input wire logic [3:0] NEG_STATUS,
   input wire logic SM_BUSY,
   input wire logic SM_STROBE,
   input wire logic [4:0] ECP_LINES,
   input wire logic EPP_ADDR_STB,
   input wire logic [7:0] EPP_ADDR,
   input wire logic DIR_CHANGE_STB,
   input wire logic ID_REQ_STB,
   output logic PERIPHERAL_BUSY_LINE,
   output logic PERIPHERAL_STROBE_LINE,
   output logic ACK_REQUEST_LINE,
   output logic EXTENSION_FLAG_LINE,
   output logic DATA_AVAILABLE_LOW_LINE_N,
   output logic PAR_IRQ
);
   // ******************************************************
   // declarations
   // ******************************************************
   ppoi_reg_if rif ();
   logic [7:0] cfg_reg;
   logic [7:0] en_reg;
   logic [7:0] stat_reg;
   logic [7:0] stat_next;
   logic [7:0] ovr_reg;
   logic [7:0] rise_sel_reg;
   logic [7:0] fall_sel_reg;
   logic [7:0] nsr_reg;
   logic [7:0] ear_reg;
   logic [3:0] neg_prev_reg;
   logic [7:0] events;
   logic [3:0] in_rise;
   logic [3:0] in_fall;
   logic manual;
   logic ecp;
   logic compat;
   logic neg_changed;
   logic sig_hit;
   logic st_wr;

   // ******************************************************
   // bus slave and pin synchronisers
   // ******************************************************
   ppoi_wb_slave i_ppoi_wb_slave (
      .clk(REF_CLK),
      .rst(RST),
      .cyc_i(CYC_I),
      .stb_i(STB_I),
      .we_i(WE_I),
      .adr_i(ADR_I),
      .sel_i(SEL_I),
      .dat_i(DAT_I),
      .dat_o(DAT_O),
      .ack_o(ACK_O),
      .rif(rif.slave_end)
   );

   // host lines cross in from the cable, so they are synchronised first
   ppoi_in_sync #(.W(4)) i_ppoi_in_sync (
      .clk(REF_CLK),
      .rst(RST),
      .pin(HOST_LINES),
      .level(),
      .rise(in_rise),
      .fall(in_fall)
   );

   // ******************************************************
   // mode decode
   // ******************************************************
   // negotiated status comes from the port state machine on this clock
   assign manual = cfg_reg[B_MANUAL];
   assign ecp = ppoi_is_ecp(NEG_STATUS);
   assign compat = ppoi_is_compat(NEG_STATUS);
   assign neg_changed = NEG_STATUS != neg_prev_reg;
   assign st_wr = rif.wr && rif.idx == IDX_IRQ_ST;

   // ******************************************************
   // configuration and enable registers
   // ******************************************************
   // only the manual select bit is kept; the rest read zero
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         cfg_reg <= ZERO8;
      end else if (rif.wr && rif.idx == IDX_CFG) begin
         cfg_reg <= rif.wdata & CFG_MASK;
      end
   end

   // bit seven forced zero; bit six stays writable although no event ever sets it
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         en_reg <= ZERO8;
      end else if (rif.wr && rif.idx == IDX_IRQ_EN) begin
         en_reg <= rif.wdata & IRQ_MASK;
      end
   end

   // write-only output values; reserved low bits kept at zero
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ovr_reg <= OUT_RST;
      end else if (rif.wr && rif.idx == IDX_OUT) begin
         ovr_reg <= rif.wdata & OUT_MASK;
      end
   end

   // edge selects for the monitored host inputs
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rise_sel_reg <= ZERO8;
         fall_sel_reg <= ZERO8;
      end else if (rif.wr) begin
         if (rif.idx == IDX_RISE) begin
            rise_sel_reg <= rif.wdata & SEL_MASK;
         end
         if (rif.idx == IDX_FALL) begin
            fall_sel_reg <= rif.wdata & SEL_MASK;
         end
      end
   end

   // ******************************************************
   // captured status from the protocol side
   // ******************************************************
   // previous status, used to see a negotiation change
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         neg_prev_reg <= 4'h0;
      end else begin
         neg_prev_reg <= NEG_STATUS;
      end
   end

   // new status latched on change; a write clears it, a change wins
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         nsr_reg <= ZERO8;
      end else if (neg_changed) begin
         nsr_reg <= {4'h0, NEG_STATUS};
      end else if (rif.wr && rif.idx == IDX_NSR) begin
         nsr_reg <= ZERO8;
      end
   end

   // address from the remote master, kept until the next one
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ear_reg <= ZERO8;
      end else if (EPP_ADDR_STB) begin
         ear_reg <= EPP_ADDR;
      end
   end

   // ******************************************************
   // interrupt events and status
   // ******************************************************
   // qualifying edges count only while software holds the lines
   assign sig_hit = |((in_rise & rise_sel_reg[3:0]) | (in_fall & fall_sel_reg[3:0]));

   // event vector in the shared enable and status layout
   always_comb begin
      events = ZERO8;
      events[S_NEG] = neg_changed;
      events[S_SIG] = manual && sig_hit;
      events[S_EPP_ADDRESS_WRITTEN] = EPP_ADDR_STB;
      events[S_DIR] = DIR_CHANGE_STB;
      events[S_ID] = ID_REQ_STB;
      events[S_INIT] = compat && !manual && in_fall[I_INIT];
   end

   // any write clears everything, but an event in that cycle survives
   always_comb begin
      stat_next = st_wr ? ZERO8 : stat_reg;
      stat_next = stat_next | events;
   end

   // no timer exists, so bits six and seven stay zero
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         stat_reg <= ZERO8;
      end else begin
         stat_reg <= stat_next & IRQ_MASK;
      end
   end

   // request follows pending and enabled bits, one cycle behind
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PAR_IRQ <= 1'b0;
      end else begin
         PAR_IRQ <= |(stat_reg & en_reg);
      end
   end

   // ******************************************************
   // read mux
   // ******************************************************
   // the output value register is write-only and reads zero
   always_comb begin
      unique case (rif.idx)
         IDX_CFG: rif.rdata = cfg_reg;
         IDX_IRQ_EN: rif.rdata = en_reg;
         IDX_IRQ_ST: rif.rdata = stat_reg;
         IDX_NSR: rif.rdata = nsr_reg;
         IDX_EAR: rif.rdata = ear_reg;
         IDX_RISE: rif.rdata = rise_sel_reg;
         IDX_FALL: rif.rdata = fall_sel_reg;
         default: rif.rdata = ZERO8;
      endcase
   end

   // ******************************************************
   // output line steering
   // ******************************************************
   // busy and strobe: register only in manual, else protocol logic
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         PERIPHERAL_BUSY_LINE <= OUT_RST[B_BUSY];
         PERIPHERAL_STROBE_LINE <= OUT_RST[B_STROBE];
      end else if (manual) begin
         PERIPHERAL_BUSY_LINE <= ovr_reg[B_BUSY];
         PERIPHERAL_STROBE_LINE <= ovr_reg[B_STROBE];
      end else if (ecp) begin
         PERIPHERAL_BUSY_LINE <= ECP_LINES[4];
         PERIPHERAL_STROBE_LINE <= ECP_LINES[3];
      end else begin
         PERIPHERAL_BUSY_LINE <= SM_BUSY;
         PERIPHERAL_STROBE_LINE <= SM_STROBE;
      end
   end

   // status lines: register everywhere except ecp outside manual
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ACK_REQUEST_LINE <= OUT_RST[B_ACKRQ];
         EXTENSION_FLAG_LINE <= OUT_RST[B_FLAG];
         DATA_AVAILABLE_LOW_LINE_N <= OUT_RST[B_DAV];
      end else if (ecp && !manual) begin
         ACK_REQUEST_LINE <= ECP_LINES[2];
         EXTENSION_FLAG_LINE <= ECP_LINES[1];
         DATA_AVAILABLE_LOW_LINE_N <= ECP_LINES[0];
      end else begin
         ACK_REQUEST_LINE <= ovr_reg[B_ACKRQ];
         EXTENSION_FLAG_LINE <= ovr_reg[B_FLAG];
         DATA_AVAILABLE_LOW_LINE_N <= ovr_reg[B_DAV];
      end
   end

   // ******************************************************
   // assertions
   // ******************************************************
   a_manual_lines: assert property (
      @(posedge REF_CLK) disable iff (RST)
      manual |=> PERIPHERAL_BUSY_LINE == $past(ovr_reg[B_BUSY])
         && PERIPHERAL_STROBE_LINE == $past(ovr_reg[B_STROBE])
         && DATA_AVAILABLE_LOW_LINE_N == $past(ovr_reg[B_DAV]))
      else $error("manual lines differ from output values");
   a_sm_handshake: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (!manual && !ecp) |=> PERIPHERAL_BUSY_LINE == $past(SM_BUSY)
         && PERIPHERAL_STROBE_LINE == $past(SM_STROBE))
      else $error("busy or strobe not from state machine");
   a_ecp_ignores: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (!manual && ecp) |=> {PERIPHERAL_BUSY_LINE, PERIPHERAL_STROBE_LINE,
         ACK_REQUEST_LINE, EXTENSION_FLAG_LINE,
         DATA_AVAILABLE_LOW_LINE_N} == $past(ECP_LINES))
      else $error("ecp lines not passed through");
   a_busy_gate: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (!manual && !ecp && SM_BUSY != ovr_reg[B_BUSY])
         |=> PERIPHERAL_BUSY_LINE != $past(ovr_reg[B_BUSY]))
      else $error("busy bit reached pin outside manual");
   a_status_lines: assert property (
      @(posedge REF_CLK) disable iff (RST)
      !(ecp && !manual) |=> ACK_REQUEST_LINE == $past(ovr_reg[B_ACKRQ])
         && EXTENSION_FLAG_LINE == $past(ovr_reg[B_FLAG])
         && DATA_AVAILABLE_LOW_LINE_N == $past(ovr_reg[B_DAV]))
      else $error("status line not from output value");
   a_irq_follow: assert property (
      @(posedge REF_CLK) disable iff (RST)
      ##1 PAR_IRQ == |($past(stat_reg) & $past(en_reg)))
      else $error("interrupt not pending and enabled");
   a_status_clear: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (st_wr && events == ZERO8) |=> stat_reg == ZERO8
         ##1 (!PAR_IRQ || stat_reg != ZERO8))
      else $error("status write did not clear");
   a_neg_change: assert property (
      @(posedge REF_CLK) disable iff (RST)
      neg_changed |=> stat_reg[S_NEG] && nsr_reg[3:0] == $past(NEG_STATUS))
      else $error("negotiation change lost");
   a_sig_manual: assert property (
      @(posedge REF_CLK) disable iff (RST)
      $rose(stat_reg[S_SIG]) |-> $past(manual))
      else $error("signal change outside manual");
   a_sig_keep: assert property (
      @(posedge REF_CLK) disable iff (RST)
      ($fell(manual) && $past(stat_reg[S_SIG]) && !$past(st_wr))
         |-> stat_reg[S_SIG])
      else $error("leaving manual cleared signal change");
   a_rise_select: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (manual && |(in_rise & rise_sel_reg[3:0])) |=> stat_reg[S_SIG])
      else $error("selected rising edge ignored");
   a_epp_addr: assert property (
      @(posedge REF_CLK) disable iff (RST)
      EPP_ADDR_STB |=> ear_reg == $past(EPP_ADDR) && stat_reg[S_EPP_ADDRESS_WRITTEN])
      else $error("epp address not stored");
   a_dir_id: assert property (
      @(posedge REF_CLK) disable iff (RST)
      (DIR_CHANGE_STB || ID_REQ_STB) |=> (stat_reg[S_DIR] || !$past(DIR_CHANGE_STB))
         && (stat_reg[S_ID] || !$past(ID_REQ_STB)))
      else $error("direction or identity flag missed");
   a_init_edge: assert property (
      @(posedge REF_CLK) disable iff (RST)
      $rose(stat_reg[S_INIT]) |-> $past(compat && !manual && in_fall[I_INIT]))
      else $error("init flag without compatibility edge");
   a_reset_vals: assert property (
      @(posedge REF_CLK)
      RST |-> en_reg == ZERO8 && stat_reg == ZERO8 && ovr_reg == OUT_RST)
      else $error("reset values wrong");
   c_irq_raised: cover property (@(posedge REF_CLK) disable iff (RST) $rose(PAR_IRQ));
   c_manual_sig: cover property (@(posedge REF_CLK) disable iff (RST)
      manual ##1 $rose(stat_reg[S_SIG]));
   c_ecp_mode: cover property (@(posedge REF_CLK) disable iff (RST) ecp && !manual);
   c_clear_race: cover property (@(posedge REF_CLK) disable iff (RST)
      st_wr && events != ZERO8);
endmodule

/* shared/ppoi_pkg.sv */
// register map, field positions and mode codes of the parallel output and interrupt bank
package ppoi_pkg;
   // ******************************************************
   // bus geometry
   // ******************************************************
   localparam int ADR_W = 8;
   localparam int IDX_W = 6;
   localparam int DAT_W = 32;

   // ******************************************************
   // register indices, byte address is four times the index
   // ******************************************************
   localparam logic [5:0] IDX_CFG = 6'h20;
   localparam logic [5:0] IDX_IRQ_EN = 6'h22;
   localparam logic [5:0] IDX_IRQ_ST = 6'h23;
   localparam logic [5:0] IDX_NSR = 6'h28;
   localparam logic [5:0] IDX_EAR = 6'h2A;
   localparam logic [5:0] IDX_OUT = 6'h2B;
   localparam logic [5:0] IDX_FALL = 6'h2C;
   localparam logic [5:0] IDX_RISE = 6'h2D;

   // ******************************************************
   // reset values and writable masks
   // ******************************************************
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [7:0] OUT_RST = 8'h48;
   localparam logic [7:0] OUT_MASK = 8'hF8;
   localparam logic [7:0] IRQ_MASK = 8'h7F;
   localparam logic [7:0] CFG_MASK = 8'h80;
   localparam logic [7:0] SEL_MASK = 8'h0F;

   // ******************************************************
   // field positions
   // ******************************************************
   localparam int B_BUSY = 7;
   localparam int B_STROBE = 6;
   localparam int B_ACKRQ = 5;
   localparam int B_FLAG = 4;
   localparam int B_DAV = 3;
   localparam int B_MANUAL = 7;
   localparam int S_NEG = 5;
   localparam int S_SIG = 4;
   localparam int S_EPP_ADDRESS_WRITTEN = 3;
   localparam int S_DIR = 2;
   localparam int S_ID = 1;
   localparam int S_INIT = 0;
   localparam int I_INIT = 2;

   // ******************************************************
   // negotiated status codes
   // ******************************************************
   localparam logic [3:0] MODE_COMPAT = 4'h0;
   localparam logic [3:0] MODE_EPP = 4'h6;
   localparam logic [1:0] MODE_ECP_TOP = 2'h3;

   function automatic logic ppoi_is_ecp(input logic [3:0] s);
      return s[3:2] == MODE_ECP_TOP;
   endfunction

   function automatic logic ppoi_is_compat(input logic [3:0] s);
      return s == MODE_COMPAT;
   endfunction
endpackage

/* shared/ppoi_reg_if.sv */
// register access strobes between the bus slave and the register bank
`timescale 1ns/1ps
interface ppoi_reg_if;
   logic wr;
   logic [5:0] idx;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport slave_end (output wr, output idx, output wdata, input rdata);
   modport bank_end (input wr, input idx, input wdata, output rdata);
endinterface

/* hw/ppoi_wb_slave.sv */
// classic wishbone slave answering every access after one cycle
`timescale 1ns/1ps
module ppoi_wb_slave import ppoi_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [ADR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [DAT_W-1:0] dat_i,
   output logic [DAT_W-1:0] dat_o,
   output logic ack_o,
   ppoi_reg_if.slave_end rif
);
   logic req;

   // a new request is one not yet answered
   assign req = cyc_i && stb_i && !ack_o;
   // only lane 0 carries data; other lanes are ignored
   assign rif.wr = req && we_i && sel_i[0];
   assign rif.idx = adr_i[ADR_W-1:2];
   assign rif.wdata = dat_i[7:0];

   // ack for one cycle, dropped right after so the master can release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= req;
      end
   end

   // read data captured with the ack, upper bits zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dat_o <= '0;
      end else if (req) begin
         dat_o <= {24'h000000, rif.rdata};
      end
   end
endmodule

/* hw/ppoi_in_sync.sv */
// two-stage synchroniser with edge pulses for host-side pins
`timescale 1ns/1ps
module ppoi_in_sync #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] prev_reg;
   logic [2:0] fill_reg;

   // first stage is read by the second only
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // edges held off until every stage holds a real sample, so a pin idling high
   // gives no false rising edge after reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fill_reg <= 3'h0;
      end else begin
         fill_reg <= {fill_reg[1:0], 1'b1};
      end
   end

   // edges compare the stable stages
   assign level = sync_reg;
   assign rise = sync_reg & ~prev_reg & {W{fill_reg[2]}};
   assign fall = ~sync_reg & prev_reg & {W{fill_reg[2]}};
endmodule

/* verification/ppoi_host_model.sv */
// host side parallel port model driving the four monitored host pins
`timescale 1ns/1ps
module ppoi_host_model (
   input wire logic clk,
   input wire logic init_go,
   input wire logic hclk_lvl,
   output logic [3:0] lines
);
   // ******************************************************
   // init low pulse
   // ******************************************************
   logic [2:0] cnt_reg = 3'h0;
   // seven cycles low, long enough to pass the two-stage synchroniser
   always @(posedge clk) begin
      if (init_go) begin
         cnt_reg <= 3'h7;
      end else if (cnt_reg != 3'h0) begin
         cnt_reg <= cnt_reg - 3'h1;
      end
   end
   // busy and 1284 active stay low, init idles high
   assign lines = {1'b0, cnt_reg == 3'h0, 1'b0, hclk_lvl};
endmodule

/* verification/tb_ppoi_top.sv */
// self-checking bench of the parallel output line and interrupt bank
`timescale 1ns/1ps
module tb_ppoi_top import ppoi_pkg::*; ();
   // ******************************************************
   // stimulus and design
   // ******************************************************
   logic REF_CLK = 0, RST = 0, CYC_I = 0, STB_I = 0, WE_I = 0, ACK_O, PAR_IRQ;
   logic [ADR_W-1:0] ADR_I = '0;
   logic [3:0] SEL_I = '0, HOST_LINES, NEG_STATUS = '0;
   logic [DAT_W-1:0] DAT_I = '0, DAT_O;
   logic SM_BUSY = 0, SM_STROBE = 1, EPP_ADDR_STB = 0, DIR_CHANGE_STB = 0, ID_REQ_STB = 0;
   logic [4:0] ECP_LINES = '0;
   logic [7:0] EPP_ADDR = '0;
   logic PERIPHERAL_BUSY_LINE, PERIPHERAL_STROBE_LINE, ACK_REQUEST_LINE;
   logic EXTENSION_FLAG_LINE, DATA_AVAILABLE_LOW_LINE_N, init_go = 0, hclk_lvl = 0;
   int err_count = 0, total_checks = 0;
   always #10 REF_CLK = ~REF_CLK;
   ppoi_top i_ppoi_top (.*);
   ppoi_host_model i_ppoi_host_model (.clk(REF_CLK), .init_go(init_go),
      .hclk_lvl(hclk_lvl), .lines(HOST_LINES));
   // compare and count
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // classic single cycle, held until ack is sampled high
   task automatic bus(input logic we, input logic [5:0] ix, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge REF_CLK);
      {CYC_I, STB_I, WE_I, SEL_I} <= {2'h3, we, 4'h1};
      ADR_I <= {ix, 2'h0};
      DAT_I <= {24'h0, d};
      do begin
         @(posedge REF_CLK);
      end while (ACK_O !== 1'b1);
      q = DAT_O[7:0];
      {CYC_I, STB_I, WE_I} <= 3'h0;
   endtask
   task automatic wr(input logic [5:0] ix, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, ix, d, q);
   endtask
   task automatic rdc(input string nm, input logic [5:0] ix, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, ix, 8'h00, q);
      chk(nm, e, q);
   endtask
   // lines in order busy, strobe, ack request, flag, data available low
   task automatic ln_chk(input logic [4:0] e);
      repeat (2) @(posedge REF_CLK);
      chk("lines", {3'h0, e}, {3'h0, PERIPHERAL_BUSY_LINE, PERIPHERAL_STROBE_LINE,
         ACK_REQUEST_LINE, EXTENSION_FLAG_LINE, DATA_AVAILABLE_LOW_LINE_N});
   endtask
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge REF_CLK);
      chk("irq", {7'h0, e}, {7'h0, PAR_IRQ});
   endtask
   // one-cycle event strobe, then time for sync and status to settle
   task automatic pulse(input int k);
      @(posedge REF_CLK);
      {EPP_ADDR_STB, DIR_CHANGE_STB, ID_REQ_STB, init_go} <= 4'h8 >> k;
      @(posedge REF_CLK);
      {EPP_ADDR_STB, DIR_CHANGE_STB, ID_REQ_STB, init_go} <= 4'h0;
      repeat (8) @(posedge REF_CLK);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ******************************************************
   // scenarios
   // ******************************************************
   task automatic t_reset;
      rdc("enable", IDX_IRQ_EN, ZERO8);
      rdc("status", IDX_IRQ_ST, ZERO8);
      rdc("outval", IDX_OUT, ZERO8);
      rdc("unmapped", 6'h3F, ZERO8);
      ln_chk(5'h09);
      $display("test reset done");
   endtask
   task automatic t_manual;
      wr(IDX_CFG, 8'h80);
      wr(IDX_OUT, 8'hA8);
      ln_chk(5'h15);
      wr(IDX_OUT, 8'h50);
      NEG_STATUS <= 4'hC;
      ln_chk(5'h0A);
      $display("test manual done");
   endtask
   task automatic t_modes;
      logic [3:0] m [3] = '{MODE_COMPAT, MODE_EPP, 4'hC};
      wr(IDX_CFG, 8'h00);
      {SM_BUSY, SM_STROBE} <= 2'h2;
      ECP_LINES <= 5'h12;
      foreach (m[i]) begin
         NEG_STATUS <= m[i];
         wr(IDX_OUT, 8'h30);
         ln_chk(i == 2 ? 5'h12 : 5'h16);
         wr(IDX_OUT, 8'hC8);
         ln_chk(i == 2 ? 5'h12 : 5'h11);
      end
      $display("test modes done");
   endtask
   task automatic t_events;
      wr(IDX_IRQ_ST, 8'h00);
      wr(IDX_IRQ_EN, 8'h3F);
      EPP_ADDR <= 8'h5A;
      pulse(0);
      rdc("status", IDX_IRQ_ST, 8'h08);
      rdc("address", IDX_EAR, 8'h5A);
      irq_chk(1'b1);
      wr(IDX_IRQ_ST, 8'h00);
      rdc("status", IDX_IRQ_ST, ZERO8);
      irq_chk(1'b0);
      pulse(1);
      rdc("status", IDX_IRQ_ST, 8'h04);
      pulse(2);
      rdc("status", IDX_IRQ_ST, 8'h06);
      wr(IDX_IRQ_EN, 8'h20);
      wr(IDX_IRQ_ST, 8'h3F);
      NEG_STATUS <= MODE_EPP;
      repeat (3) @(posedge REF_CLK);
      rdc("status", IDX_IRQ_ST, 8'h20);
      rdc("negstat", IDX_NSR, {4'h0, MODE_EPP});
      irq_chk(1'b1);
      wr(IDX_IRQ_EN, 8'h1F);
      irq_chk(1'b0);
      $display("test events done");
   endtask
   task automatic t_pins;
      NEG_STATUS <= MODE_COMPAT;
      repeat (3) @(posedge REF_CLK);
      wr(IDX_IRQ_ST, 8'h00);
      pulse(3);
      rdc("status", IDX_IRQ_ST, 8'h01);
      wr(IDX_CFG, 8'h80);
      rdc("config", IDX_CFG, 8'h80);
      wr(IDX_IRQ_ST, 8'h00);
      wr(IDX_RISE, 8'h01);
      hclk_lvl <= 1'b1;
      repeat (8) @(posedge REF_CLK);
      rdc("status", IDX_IRQ_ST, 8'h10);
      wr(IDX_IRQ_ST, 8'h00);
      wr(IDX_FALL, 8'h01);
      rdc("fallsel", IDX_FALL, 8'h01);
      hclk_lvl <= 1'b0;
      repeat (8) @(posedge REF_CLK);
      rdc("status", IDX_IRQ_ST, 8'h10);
      wr(IDX_CFG, 8'h00);
      rdc("status", IDX_IRQ_ST, 8'h10);
      $display("test pins done");
   endtask
   // ******************************************************
   // main sequence and watchdog
   // ******************************************************
   initial begin
      // raised by an edge at time zero so the asynchronous branch really fires
      RST <= 1'b1;
      repeat (12) @(posedge REF_CLK);
      RST <= 1'b0;
      t_reset();
      t_manual();
      t_modes();
      t_events();
      t_pins();
      end_sim();
   end
   // whole run needs well under a thousand cycles
   initial begin
      #1000000;
      err_count++;
      end_sim();
   end
endmodule
